// ### logic/sdsr_pkg.sv
package sdsr_pkg;
   // register map and field layout
   localparam logic [7:0] SDSR_DATA_ADDR = 8'hc2;
   localparam logic [7:0] SDSR_CTRL_ADDR = 8'hc0;
   localparam logic [7:0] SDSR_CFG_ADDR = 8'hc1;
   localparam int SDSR_SI_BIT = 0;
   localparam int SDSR_EN_BIT = 7;
   localparam logic [7:0] SDSR_DATA_RESET = 8'h00;
   localparam int SDSR_BYTE_BITS = 8;
   localparam logic [3:0] SDSR_LAST_BIT = 4'h7;
endpackage

// ### logic/sdsr_shifter.sv
`timescale 1ns/100ps
// byte shifter: loads, shifts sampled bit in at lsb, msb presented
module sdsr_shifter #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] load_data_i,
   input wire logic shift_i,
   input wire logic sample_i,
   output logic [WIDTH-1:0] data_o
);
   // elaboration-time guard: a one-bit shifter has no msb to present
   if (WIDTH < 2) begin : g_width_check
      $error("sdsr_shifter: WIDTH must be at least 2");
   end

   // load has priority; shift brings the bus bit in at lsb
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         data_o <= '0;
      end else if (load_i) begin
         data_o <= load_data_i;
      end else if (shift_i) begin
         data_o <= {data_o[WIDTH-2:0], sample_i};
      end
   end
endmodule

// ### logic/sdsr_top.sv
`timescale 1ns/100ps
// Functional notes
// - eight-bit register holds send or received byte
// - cpu access allowed while interrupt flag set
// - transmit starts with msb, ends lsb
// - first received bit lands in msb
// - bus bit shifted in per bit out
// - register ends holding last bus byte
// - lost arbitration keeps correct bus byte
// - no shifting while interrupt flag set
// - enable bit starts bus monitoring
module sdsr_top (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic [7:0] bus_control_register_i,
   input wire logic [7:0] cfg_register_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic drive_en_i,
   input wire logic arb_lost_i,
   output logic sda_bit_o,
   output logic [3:0] bit_count_o,
   output logic byte_done_o
);
   import sdsr_pkg::*;

   // byte phase: off, frozen by the flag, shifting, or lost to a master
   typedef enum logic [3:0] {
      SDSR_ST_OFF = 4'b0001,
      SDSR_ST_HELD = 4'b0010,
      SDSR_ST_SHIFT = 4'b0100,
      SDSR_ST_LOST = 4'b1000
   } sdsr_state_t;

   // picks one control bit out of a register image
   function automatic logic sdsr_field(input logic [7:0] value,
      input int pos);
      sdsr_field = value[pos[2:0]];
   endfunction

   // wrap-around step of the bit counter, back to zero after bit seven
   function automatic logic [3:0] sdsr_step(input logic [3:0] cnt);
      if (cnt == SDSR_LAST_BIT) begin
         sdsr_step = 4'h0;
      end else begin
         sdsr_step = cnt + 4'h1;
      end
   endfunction

   // shift register image and its bookkeeping
   logic [7:0] smbus_data_byte;
   logic scl_q;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   sdsr_state_t state;
   sdsr_state_t next_state;

   // control decode from the two register images
   wire serial_iface_enable = sdsr_field(cfg_register_i, SDSR_EN_BIT);
   wire si_flag = sdsr_field(bus_control_register_i, SDSR_SI_BIT);
   wire data_sel = (sfr_addr_i == SDSR_DATA_ADDR);

   // cpu may write the byte only while the flag holds the bus or the interface is disabled;
   // a write at any other time while enabled is dropped silently
   wire cpu_ok = si_flag || !serial_iface_enable;
   wire cpu_load = data_sel && sfr_wr_i && cpu_ok;
   wire cpu_read = data_sel && sfr_rd_i;

   // monitoring only while enabled; rising scl samples sda
   wire scl_rise = serial_iface_enable && scl_i && !scl_q;

   // bus sampled into lsb whether we drove it or not;
   // the flag freezes the byte so the cpu sees a stable value
   wire do_shift = scl_rise && !si_flag;
   wire last_bit = (bit_cnt == SDSR_LAST_BIT);
   wire byte_end = do_shift && last_bit;

   // the line level, not our own bit, is what gets captured
   wire shift_bit = sda_i;

   // after a lost arbitration we stop driving but keep sampling,
   // so the byte still ends up as the one seen on the bus
   wire lost_next = (next_state == SDSR_ST_LOST);
   wire release_sda = !drive_en_i || lost_next;

   // next values of the registered outputs
   wire next_sda = release_sda || smbus_data_byte[7];
   wire next_done = byte_end;
   wire [7:0] next_rdata = cpu_read ? smbus_data_byte : 8'h00;

   // the byte itself: cpu load wins over a bus shift
   sdsr_shifter #(.WIDTH(SDSR_BYTE_BITS)) u_shift (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(cpu_load),
      .load_data_i(sfr_wdata_i),
      .shift_i(do_shift),
      .sample_i(shift_bit),
      .data_o(smbus_data_byte)
   );

   // bit counter restarts on load or disable, wraps after bit seven
   always_comb begin
      if (!serial_iface_enable || cpu_load) begin
         next_bit_cnt = 4'h0;
      end else if (do_shift) begin
         next_bit_cnt = sdsr_step(bit_cnt);
      end else begin
         next_bit_cnt = bit_cnt;
      end
   end

   // byte phase tracking; disable always wins, then the flag
   always_comb begin
      next_state = state;
      case (state)
         SDSR_ST_OFF: begin
            if (serial_iface_enable && si_flag) begin
               next_state = SDSR_ST_HELD;
            end else if (serial_iface_enable) begin
               next_state = SDSR_ST_SHIFT;
            end
         end
         SDSR_ST_HELD: begin
            if (!serial_iface_enable) begin
               next_state = SDSR_ST_OFF;
            end else if (!si_flag) begin
               next_state = SDSR_ST_SHIFT;
            end
         end
         SDSR_ST_SHIFT: begin
            if (!serial_iface_enable) begin
               next_state = SDSR_ST_OFF;
            end else if (si_flag) begin
               next_state = SDSR_ST_HELD;
            end else if (arb_lost_i) begin
               next_state = SDSR_ST_LOST;
            end
         end
         SDSR_ST_LOST: begin
            if (!serial_iface_enable) begin
               next_state = SDSR_ST_OFF;
            end else if (si_flag) begin
               next_state = SDSR_ST_HELD;
            end
         end
         default: begin
            next_state = SDSR_ST_OFF;
         end
      endcase
   end

   // scl edge history; idles high like the bus so reset makes no edge
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         scl_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
      end
   end

   // byte phase register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= SDSR_ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // bit counter register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bit_cnt <= 4'h0;
      end else begin
         bit_cnt <= next_bit_cnt;
      end
   end

   // msb presented to the open-drain sda driver, high when released
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sda_bit_o <= 1'b1;
      end else begin
         sda_bit_o <= next_sda;
      end
   end

   // bit count seen by the rest of the unit
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bit_count_o <= 4'h0;
      end else begin
         bit_count_o <= bit_cnt;
      end
   end

   // one-cycle pulse after the eighth bit has been shifted
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         byte_done_o <= 1'b0;
      end else begin
         byte_done_o <= next_done;
      end
   end

   // read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sfr_rdata_o <= SDSR_DATA_RESET;
      end else begin
         sfr_rdata_o <= next_rdata;
      end
   end
endmodule

// ### sim/sdsr_asserts.sv
`timescale 1ns/100ps
// port checks on the data shift register
module sdsr_asserts
   import sdsr_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic [7:0] bus_control_register_i,
   input wire logic [7:0] cfg_register_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic drive_en_i,
   input wire logic arb_lost_i,
   input wire logic sda_bit_o,
   input wire logic [3:0] bit_count_o,
   input wire logic byte_done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // scl held low for four samples in a row
   sequence s_scl_low;
      !scl_i [*4];
   endsequence

   // shifting, enabled and flag clear for two samples
   sequence s_shifting;
      !$past(bus_control_register_i[0]) && !$past(bus_control_register_i[0], 2)
      && $past(cfg_register_i[7]) && $past(cfg_register_i[7], 2);
   endsequence

   a_rd_idle: assert property (
      !$past(sfr_rd_i) |-> sfr_rdata_o == 8'h00)
      else $error("read data not zero while idle");
   a_rd_other: assert property (
      $past(sfr_rd_i) && ($past(sfr_addr_i) != SDSR_DATA_ADDR)
      |-> sfr_rdata_o == 8'h00)
      else $error("read data on other address");
   a_sda_release: assert property (
      !$past(drive_en_i) |-> sda_bit_o)
      else $error("sda driven while not sending");
   a_flag_freeze: assert property (
      $past(bus_control_register_i[0], 2) && $past(cfg_register_i[7], 2)
      && !$past(sfr_wr_i, 2) |-> $stable(bit_count_o))
      else $error("bit count moved while flag set");
   a_done_once: assert property (
      byte_done_o |=> !byte_done_o [*8])
      else $error("byte done repeated");
   a_reset_sda: assert property (
      $past(sys_rst_i) |-> sda_bit_o)
      else $error("sda not released after reset");
   a_off_idle: assert property (
      !$past(cfg_register_i[7]) && !$past(cfg_register_i[7], 2)
      |-> !byte_done_o)
      else $error("byte done while disabled");
   a_scl_low: assert property (
      s_scl_low |-> !byte_done_o)
      else $error("byte done without scl rise");
   a_lost_release: assert property (
      s_shifting and $past(arb_lost_i) |-> sda_bit_o)
      else $error("sda still driven after lost arbitration");
endmodule

bind sdsr_top sdsr_asserts chk (
   .clk_i(clk_i),
   .sys_rst_i(sys_rst_i),
   .sfr_addr_i(sfr_addr_i),
   .sfr_wr_i(sfr_wr_i),
   .sfr_rd_i(sfr_rd_i),
   .sfr_wdata_i(sfr_wdata_i),
   .sfr_rdata_o(sfr_rdata_o),
   .bus_control_register_i(bus_control_register_i),
   .cfg_register_i(cfg_register_i),
   .scl_i(scl_i),
   .sda_i(sda_i),
   .drive_en_i(drive_en_i),
   .arb_lost_i(arb_lost_i),
   .sda_bit_o(sda_bit_o),
   .bit_count_o(bit_count_o),
   .byte_done_o(byte_done_o)
);

// ### sim/sdsr_bus_model.sv
`timescale 1ns/100ps
// far side: drives scl and its sda bits, open drain with pull-ups
module sdsr_bus_model (
   input wire logic clk_i,
   input wire logic dev_sda_i,
   output logic scl_o,
   output logic sda_o
);
   logic bit_q = 1'b1;
   logic [7:0] seen = 8'h00;

   // scl idles high between bytes
   initial begin
      scl_o = 1'b1;
   end

   // wired-and of both drivers; pull-up level when both release
   assign sda_o = bit_q & dev_sda_i;

   // one byte msb first, bits moved only while scl low; line released with scl high after the last bit
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_i) #1 scl_o = 1'b0;
         bit_q = b[i];
         repeat (4) @(posedge clk_i);
         #1 scl_o = 1'b1;
         seen = {seen[6:0], sda_o};
         repeat (2) @(posedge clk_i);
      end
      #1 bit_q = 1'b1;
   endtask
endmodule

// ### sim/sdsr_top_tb.sv
`timescale 1ns/100ps
module sdsr_top_tb;
   import sdsr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic den = 1'b0;
   logic arb = 1'b0;
   logic scl;
   logic sda;
   logic sdo;
   logic [7:0] addr = SDSR_DATA_ADDR;
   logic [7:0] ctl = 8'h01;
   logic [7:0] cfg = 8'h80;
   logic [7:0] wd = 8'h00;
   logic [7:0] rdat;
   int error_cnt = 0;
   int n_checks = 0;
   initial begin
      forever #10 clk = ~clk;
   end
   sdsr_top dut (.clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(addr),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat),
      .bus_control_register_i(ctl), .cfg_register_i(cfg), .scl_i(scl),
      .sda_i(sda), .drive_en_i(den), .arb_lost_i(arb), .sda_bit_o(sdo),
      .bit_count_o(), .byte_done_o());
   sdsr_bus_model bm (.clk_i(clk), .dev_sda_i(sdo), .scl_o(scl), .sda_o(sda));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   // one register access, write or read
   task sfr(input logic w, input logic [7:0] d);
      @(posedge clk) #1 {wr, rd, wd} = {w, !w, d};
      @(posedge clk) #1 {wr, rd} = 2'b00;
   endtask
   // device sends d while far side sends p; bus carries d & p
   task xfer(input logic [7:0] d, p);
      sfr(1'b1, d);
      {den, ctl} = 9'h100;
      bm.send(p);
      ctl = 8'h01;
      chk(bm.seen, d & p);
      sfr(1'b0, 8'h00);
      chk(rdat, d & p);
   endtask
   // shifting held off while the flag is set
   task frozen;
      den = 1'b0;
      bm.send(8'h00);
      sfr(1'b0, 8'h00);
      chk(rdat, 8'h3c);
   endtask
   // other addresses neither load nor return the byte
   task other_addr;
      addr = SDSR_CTRL_ADDR;
      sfr(1'b1, 8'h77);
      sfr(1'b0, 8'h00);
      chk(rdat, 8'h00);
      addr = SDSR_DATA_ADDR;
      sfr(1'b0, 8'h00);
      chk(rdat, 8'h05);
   endtask
   // a write while enabled and the flag is clear is dropped
   task refused;
      ctl = 8'h00;
      sfr(1'b1, 8'h99);
      ctl = 8'h01;
      sfr(1'b0, 8'h00);
      chk(rdat, 8'h3c);
   endtask
   // arbitration lost before the byte: only the far side's bits remain
   task lost;
      sfr(1'b1, 8'hf0);
      {den, ctl} = 9'h100;
      @(posedge clk) #1 arb = 1'b1;
      @(posedge clk) #1 arb = 1'b0;
      bm.send(8'h5a);
      ctl = 8'h01;
      chk(bm.seen, 8'h5a);
      sfr(1'b0, 8'h00);
      chk(rdat, 8'h5a);
      den = 1'b0;
   endtask
   // disabled interface ignores bus traffic
   task off_mode;
      {cfg, ctl} = 16'h0000;
      bm.send(8'h00);
      {cfg, ctl} = 16'h8001;
      sfr(1'b0, 8'h00);
      chk(rdat, 8'h5a);
   endtask
   // reset in mid-run returns the byte to its reset value
   task mid_reset;
      @(posedge clk) #1 rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      sfr(1'b0, 8'h00);
      chk(rdat, SDSR_DATA_RESET);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 0;
      sfr(1'b0, 8'h00);
      chk(rdat, SDSR_DATA_RESET);
      xfer(8'ha5, 8'h0f);
      other_addr;
      xfer(8'h3c, 8'hff);
      frozen;
      refused;
      lost;
      off_mode;
      mid_reset;
      report_and_stop;
   end
   // run limit: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("[ERR] %0t run limit reached", $time);
      report_and_stop;
   end
endmodule
